// File: design/srf_pkg.sv
// constants and carrier types for the sample-rate and filter control block
// assumes a single 20 MHz system clock and a decoded 16-bit serial command word
package srf_pkg;

  // command word as it arrives from the serial port: write flag, address, data byte
  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] data;
  } srf_cmd_t;

  typedef logic signed [15:0] srf_word_t;

  // register byte addresses
  localparam logic [6:0] ADDR_SMPL_LO  = 7'h36;
  localparam logic [6:0] ADDR_SMPL_HI  = 7'h37;
  localparam logic [6:0] ADDR_AVG_LO   = 7'h38;
  localparam logic [6:0] ADDR_AVG_HI   = 7'h39;
  localparam logic [6:0] ADDR_SEQ      = 7'h3a;
  localparam logic [6:0] ADDR_DIAG     = 7'h3c;
  localparam logic [6:0] ADDR_INERT    = 7'h04;
  localparam logic [6:0] ADDR_MAG      = 7'h10;
  localparam logic [6:0] ADDR_TEMP     = 7'h18;
  localparam logic [6:0] ADDR_WORD_MSK = 7'h7e;
  localparam int unsigned MAG_REGS     = 4;

  // field widths and positions
  localparam int unsigned DEC_W        = 5;
  localparam int unsigned FILT_W       = 3;
  localparam int unsigned RANGE_W      = 3;
  localparam int unsigned SEQ_W        = 7;
  localparam int unsigned CLKSEL_BIT   = 0;
  localparam int unsigned DIAG_NEW_BIT = 7;

  // reset values
  localparam logic [15:0] SMPL_RST = 16'h0001;
  localparam logic [15:0] AVG_RST  = 16'h0402;

  // gyroscope ranges and the smallest filter field each allows
  localparam logic [RANGE_W-1:0] RANGE_1000 = 3'h4;
  localparam logic [RANGE_W-1:0] RANGE_500  = 3'h2;
  localparam logic [RANGE_W-1:0] RANGE_250  = 3'h1;
  localparam logic [FILT_W-1:0]  MIN_B_500  = 3'h2;
  localparam logic [FILT_W-1:0]  MIN_B_250  = 3'h4;

  // sequence counter span
  localparam logic [SEQ_W-1:0] SEQ_TOP = 7'h10;
  localparam logic [SEQ_W-1:0] SEQ_END = 7'h01;

  // timing: internal sample rate in milli-samples per second
  localparam longint CLK_HZ        = 20000000;
  localparam longint INT_SPS_MILLI = 819200;
  localparam longint INT_TICK_CYC  = (CLK_HZ * 1000) / INT_SPS_MILLI;

endpackage

// File: design/srf_top.sv
// sample clock selection, two-stage bartlett filter, decimation, new-data
// sequencing and register file; sample fifo in its own module at the end
// assumes the serial port delivers whole 16-bit command words on sys_clk

// Overview of operation
// - internal clock, no decimation: 819.2 SPS updates
// - decimation field halves rate per step
// - decimate by averaging each period's samples
// - temperature output follows decimated update rate
// - clock-select bit: one internal, zero external
// - two equal cascaded averagers, 3-bit size
// - each stage uses two-to-B taps
// - range field selects 1000/500/250 deg/s
// - 500 forces B>=2, 250 forces B>=4
// - internal clock: magnetic/pressure at 51.2 SPS
// - external clock: magnetic/pressure every sixteen
// - magnetic rate fixed unless decimation exceeds four
// - new-data bit sets on magnetic update
// - new-data clears on magnetic/pressure read
// - counter 16/2^D down to 1, reload; 1 when D > 4
// - counter is 16/2^D on magnetic update, 1 when D > 4
// - reset values 0x0001 and 0x0402
// - external select overrides line four config
// - status read leaves new-data bit alone
module srf_top
  import srf_pkg::*;
#(
  parameter int unsigned NCH      = 6,
  parameter int unsigned TICK_CYC = 32'(INT_TICK_CYC),
  parameter int unsigned FIFO_DEP = 4
) (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  // serial command port
  input  wire logic                       cmd_valid,
  input  wire srf_cmd_t                   cmd,
  output logic                            rd_valid,
  output logic [15:0]                     rd_data,
  // sensor samples
  input  wire logic                       smp_valid,
  input  wire logic [NCH:0][15:0]         smp_data,
  output logic                            smp_ready,
  input  wire logic [MAG_REGS-1:0][15:0]  mag_in,
  // line four: external sample clock or general purpose
  input  wire logic                       aux_io_line_four_in,
  input  wire logic                       gpio4_dir,
  input  wire logic                       gpio4_level,
  output logic                            aux_io_line_four_out,
  output logic                            aux_io_line_four_oe,
  // update pulse
  output logic                            out_update
);

  localparam int unsigned HW    = FILT_W + 4;
  localparam int unsigned HD    = 2 ** (2 ** FILT_W - 1);
  localparam int unsigned PW    = 2 ** FILT_W - 1;
  localparam int unsigned SW    = 16 + PW;
  localparam int unsigned ACCW  = 16 + 2 ** DEC_W;
  localparam int unsigned TICKW = $clog2(TICK_CYC + 1);

  typedef struct packed {
    logic                           clk_int;
    logic [DEC_W-1:0]               dec;
    logic [RANGE_W-1:0]             range;
    logic [FILT_W-1:0]              filt;
    logic [2:0]                     ext_sync;
    logic                           ext_lvl;
    logic [TICKW-1:0]               tick_cnt;
    logic [PW-1:0]                  wp;
    logic [NCH-1:0][HD-1:0][15:0]   h1;
    logic [NCH-1:0][HD-1:0][15:0]   h2;
    logic [NCH-1:0][SW-1:0]         s1;
    logic [NCH-1:0][SW-1:0]         s2;
    logic [NCH-1:0][ACCW-1:0]       acc;
    logic [31:0]                    dcnt;
    logic [NCH-1:0][15:0]           dout;
    logic [15:0]                    temp;
    logic [MAG_REGS-1:0][15:0]      mag;
    logic [SEQ_W-1:0]               seq;
    logic                           newmag;
    logic [15:0]                    rdata;
    logic                           rvalid;
    logic                           io4_oe;
    logic                           io4_out;
    logic                           upd;
  } srf_state_t;

  srf_state_t st_r;
  srf_state_t st_nxt;

  logic             fifo_valid;
  logic [NCH:0][15:0] fifo_data;
  logic             tick;
  logic             take;
  logic             rd_cmd;
  logic             rd_mag;
  logic             mag_upd;
  logic             lvl_nxt;
  logic [6:0]       waddr;
  logic             last;

  srf_fifo #(
    .WIDTH (16 * (NCH + 1)),
    .DEPTH (FIFO_DEP)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (smp_valid),
    .in_data   (smp_data),
    .in_ready  (smp_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (tick)
  );

  // smallest filter field the selected range allows
  function automatic logic [FILT_W-1:0] clamp_b(input logic [RANGE_W-1:0] r, input logic [FILT_W-1:0] b);
    logic [FILT_W-1:0] m;
    m = (r == RANGE_250) ? MIN_B_250 : (r == RANGE_500) ? MIN_B_500 : '0;
    return (b < m) ? m : b;
  endfunction

  always_comb begin
    logic [PW-1:0]          idx;
    logic signed [SW-1:0]   s1n;
    logic signed [SW-1:0]   s2n;
    logic signed [15:0]     y1;
    logic signed [15:0]     y2;
    logic signed [ACCW-1:0] accn;
    idx  = st_r.wp - PW'(32'(1) << st_r.filt);
    s1n  = '0;
    s2n  = '0;
    y1   = '0;
    y2   = '0;
    accn = '0;
    // at-or-past, so a smaller exponent written mid-period still closes the period
    last = (st_r.dcnt >= ((32'(1) << st_r.dec) - 32'd1));
    st_nxt = st_r;
    // sample clock: internal divider or filtered external edge
    st_nxt.ext_sync = {st_r.ext_sync[1:0], aux_io_line_four_in};
    lvl_nxt = (st_r.ext_sync[1] == st_r.ext_sync[2]) ? st_r.ext_sync[2] : st_r.ext_lvl;
    st_nxt.ext_lvl = lvl_nxt;
    st_nxt.tick_cnt = (st_r.tick_cnt == TICKW'(TICK_CYC - 1)) ? '0 : st_r.tick_cnt + TICKW'(1);
    tick = st_r.clk_int ? (st_r.tick_cnt == TICKW'(TICK_CYC - 1)) : (lvl_nxt & ~st_r.ext_lvl);
    take = tick & fifo_valid;
    st_nxt.upd = 1'b0;
    mag_upd = 1'b0;
    if (take) begin
      st_nxt.wp = st_r.wp + PW'(1);
      st_nxt.dcnt = last ? '0 : st_r.dcnt + 32'd1;
      for (int c = 0; c < NCH; c++) begin
        // two equal boxcars; history ring is as long as the widest stage
        s1n = $signed(st_r.s1[c]) + SW'($signed(fifo_data[c])) - SW'($signed(st_r.h1[c][idx]));
        y1  = 16'(s1n >>> st_r.filt);
        s2n = $signed(st_r.s2[c]) + SW'(y1) - SW'($signed(st_r.h2[c][idx]));
        y2  = 16'(s2n >>> st_r.filt);
        st_nxt.s1[c] = s1n;
        st_nxt.s2[c] = s2n;
        st_nxt.h1[c][st_r.wp] = fifo_data[c];
        st_nxt.h2[c][st_r.wp] = y1;
        accn = $signed(st_r.acc[c]) + ACCW'(y2);
        st_nxt.acc[c] = last ? '0 : accn;
        if (last) begin
          st_nxt.dout[c] = 16'(accn >>> st_r.dec);
        end
      end
      if (last) begin
        st_nxt.upd = 1'b1;
        st_nxt.temp = fifo_data[NCH];
        // span of 16 samples folded into 16/2^D updates; one update when D > 4
        if (st_r.seq <= SEQ_END) begin
          st_nxt.seq = (st_r.dec > DEC_W'(4)) ? SEQ_END : SEQ_TOP >> st_r.dec;
          mag_upd = 1'b1;
        end else begin
          st_nxt.seq = st_r.seq - SEQ_W'(1);
        end
      end
    end
    if (mag_upd) begin
      st_nxt.mag = mag_in;
    end
    // register access
    rd_cmd = cmd_valid & ~cmd.wr;
    waddr  = cmd.addr & ADDR_WORD_MSK;
    rd_mag = rd_cmd && (waddr >= ADDR_MAG) && (waddr < ADDR_MAG + 7'(2 * MAG_REGS));
    st_nxt.newmag = mag_upd | (st_r.newmag & ~rd_mag);
    st_nxt.rvalid = rd_cmd;
    st_nxt.rdata = '0;
    if (rd_cmd) begin
      unique case (waddr)
        ADDR_SMPL_LO: st_nxt.rdata = {3'h0, st_r.dec, 7'h00, st_r.clk_int};
        ADDR_AVG_LO:  st_nxt.rdata = {5'h00, st_r.range, 5'h00, st_r.filt};
        ADDR_SEQ:     st_nxt.rdata = {9'h000, st_r.seq};
        ADDR_DIAG:    st_nxt.rdata = 16'(st_r.newmag) << DIAG_NEW_BIT;
        ADDR_TEMP:    st_nxt.rdata = st_r.temp;
        default: begin
          for (int c = 0; c < NCH; c++) begin
            if (waddr == ADDR_INERT + 7'(2 * c)) begin
              st_nxt.rdata = st_r.dout[c];
            end
          end
          for (int m = 0; m < MAG_REGS; m++) begin
            if (waddr == ADDR_MAG + 7'(2 * m)) begin
              st_nxt.rdata = st_r.mag[m];
            end
          end
        end
      endcase
    end
    if (cmd_valid && cmd.wr) begin
      unique case (cmd.addr)
        ADDR_SMPL_LO: st_nxt.clk_int = cmd.data[CLKSEL_BIT];
        ADDR_SMPL_HI: st_nxt.dec = cmd.data[DEC_W-1:0];
        ADDR_AVG_LO:  st_nxt.filt = clamp_b(st_r.range, cmd.data[FILT_W-1:0]);
        ADDR_AVG_HI: begin
          if (cmd.data[RANGE_W-1:0] inside {RANGE_1000, RANGE_500, RANGE_250}) begin
            st_nxt.range = cmd.data[RANGE_W-1:0];
            st_nxt.filt = clamp_b(cmd.data[RANGE_W-1:0], st_r.filt);
          end
        end
        default: ;
      endcase
    end
    // a new tap count restarts both stages from empty history; a running sum
    // would otherwise keep the old window's excess forever
    if (st_nxt.filt != st_r.filt) begin
      st_nxt.s1 = '0;
      st_nxt.s2 = '0;
      st_nxt.h1 = '0;
      st_nxt.h2 = '0;
    end
    // external sampling owns line four, so the line only drives when internal
    st_nxt.io4_oe  = st_nxt.clk_int & gpio4_dir;
    st_nxt.io4_out = st_nxt.clk_int & gpio4_dir & gpio4_level;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r         <= '0;
      st_r.clk_int <= SMPL_RST[CLKSEL_BIT];
      st_r.dec     <= SMPL_RST[8 +: DEC_W];
      st_r.range   <= AVG_RST[8 +: RANGE_W];
      st_r.filt    <= AVG_RST[FILT_W-1:0];
      st_r.seq     <= SEQ_END;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_valid             = st_r.rvalid;
  assign rd_data              = st_r.rdata;
  assign aux_io_line_four_out = st_r.io4_out;
  assign aux_io_line_four_oe  = st_r.io4_oe;
  assign out_update           = st_r.upd;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence seq_wrap;
    st_r.upd && st_r.seq == SEQ_TOP;
  endsequence
  sequence seq_magrd;
    rd_mag && !mag_upd;
  endsequence

  AST_SEQ_RELOAD: assert property (take && last && st_r.seq <= SEQ_END && st_r.dec == '0 |=> seq_wrap)
    else $error("sequence counter did not reload to 16");
  AST_SEQ_DOWN: assert property (take && last && st_r.seq > SEQ_END |=> st_r.seq == $past(st_r.seq) - 7'h01)
    else $error("sequence counter did not step down");
  AST_SEQ_SPAN: assert property (take && last && st_r.seq <= SEQ_END && st_r.dec != '0 && st_r.dec <= 5'h04
    |=> st_r.seq == (SEQ_TOP >> $past(st_r.dec)))
    else $error("sequence counter outside its span");
  AST_NEW_SET: assert property (mag_upd |=> st_r.newmag && st_r.mag == $past(mag_in))
    else $error("new-data bit or magnetic data missing after update");
  AST_NEW_CLR: assert property (seq_magrd |=> !st_r.newmag && st_r.rvalid)
    else $error("new-data bit not cleared by data read");
  AST_DIAG_KEEP: assert property (rd_cmd && waddr == ADDR_DIAG && st_r.newmag |=> st_r.newmag && st_r.rdata[DIAG_NEW_BIT])
    else $error("status read disturbed the new-data bit");
  AST_CLAMP: assert property (st_r.range == RANGE_250 |-> st_r.filt >= MIN_B_250)
    else $error("filter field below range minimum");
  AST_IO4: assert property (!st_r.clk_int |-> !aux_io_line_four_oe)
    else $error("line four driven with external sampling");
  AST_MAG_AT_TOP: assert property (mag_upd |=>
    st_r.seq == (($past(st_r.dec) > 5'h04) ? SEQ_END : SEQ_TOP >> $past(st_r.dec)))
    else $error("magnetic update not aligned to counter top");

endmodule

// sample fifo: flip-flop storage indexed by pointers; ready is registered
module srf_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);

  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
    logic                        rdy;
  } srf_fifo_state_t;

  srf_fifo_state_t st_r;
  srf_fifo_state_t st_nxt;
  logic            push;
  logic            pop;

  always_comb begin
    st_nxt = st_r;
    push = in_valid & st_r.rdy;
    pop  = out_ready & (st_r.cnt != '0);
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + AW'(1);
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + AW'(1);
    end
    st_nxt.cnt = st_r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    st_nxt.rdy = st_nxt.cnt != (AW + 1)'(DEPTH);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r     <= '0;
      st_r.rdy <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign in_ready  = st_r.rdy;
  assign out_valid = st_r.cnt != '0;
  assign out_data  = st_r.mem[st_r.rp];

endmodule

// File: sim/srf_host.sv
// host model driving the decoded register command port
// assumes sys_clk from the bench; requests change 1 ns after the rising edge
module srf_host
  import srf_pkg::*;
(
  // clock
  input  wire logic        sys_clk,
  // command port
  output srf_cmd_t         cmd,
  output logic             cmd_valid,
  input  wire logic        rd_valid,
  input  wire logic [15:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cmd_valid = 1'b0;
    cmd       = '0;
  end

  // a released word is inverted so that stale data never passes as a request
  task automatic send(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b1;
    cmd       = '{wr: w, addr: a, data: d};
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    cmd       = ~cmd;
  endtask

  // the answer stands only in the cycle after the taken edge
  task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic ok);
    send(1'b0, a, 8'h00);
    ok = rd_valid;
    d  = rd_data;
  endtask
endmodule

// File: sim/srf_top_tb.sv
// self-checking bench for the sample-rate and filter control block
// assumes the host model in srf_host.sv; the sample tick is shortened to 20 cycles
module srf_top_tb
  import srf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned TICK = 20;

  logic                      sys_clk = 1'b0;
  logic                      rst = 1'b1;
  logic                      cmd_valid, rd_valid, smp_valid, smp_ready;
  logic                      line_in, line_out, line_oe, out_update;
  logic                      gpio4_dir, gpio4_level;
  logic                      ext_on = 1'b0;
  logic                      ext_lvl = 1'b0;
  srf_cmd_t                  cmd;
  logic [15:0]               rd_data, va, vb;
  logic [6:0][15:0]          smp_data;
  logic [MAG_REGS-1:0][15:0] mag_in;
  bit                        alt, hs;
  int                        n_fail, cmp_count, n;
  // {write addr, byte, word read back}
  logic [31:0] tbl [11] = '{32'h37ff1f01, 32'h36fe1f00, 32'h36011f01, 32'h37000001, 32'h38000400,
                            32'h39020202, 32'h38010202, 32'h39010104, 32'h39030104, 32'h39040404,
                            32'h38000400};

  always #25 sys_clk = ~sys_clk;
  // the device wins the line while it drives it
  assign line_in = line_oe ? line_out : ext_lvl;
  always #750 ext_lvl = ext_on ? !ext_lvl : 1'b0;

  // words alternate between va and vb on each accepted handshake
  always @(posedge sys_clk) begin
    #1;
    if (hs) alt = !alt;
    smp_data = {7{alt ? va : vb}};
    hs = smp_valid && smp_ready;
  end

  srf_host h (.sys_clk(sys_clk), .cmd(cmd), .cmd_valid(cmd_valid), .rd_valid(rd_valid), .rd_data(rd_data));

  srf_top #(.NCH(6), .TICK_CYC(TICK), .FIFO_DEP(4)) uut (
    .sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .rd_valid(rd_valid),
    .rd_data(rd_data), .smp_valid(smp_valid), .smp_data(smp_data), .smp_ready(smp_ready),
    .mag_in(mag_in), .aux_io_line_four_in(line_in), .gpio4_dir(gpio4_dir), .gpio4_level(gpio4_level),
    .aux_io_line_four_out(line_out), .aux_io_line_four_oe(line_oe), .out_update(out_update));

  function automatic logic [15:0] exp_avg(input logic [15:0] a, input logic [15:0] b);
    logic signed [16:0] s;
    s = $signed({a[15], a}) + $signed({b[15], b});
    return s[16:1];
  endfunction

  function automatic logic [15:0] exp_span(input int d);
    return 16'h0010 >> d;
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rchk(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic        ok;
    h.rd(a, d, ok);
    chk("read valid", 16'h0001, {15'h0, ok});
    chk($sformatf("register %h", a), e, d);
  endtask

  task automatic wait_upd();
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (out_update !== 1'b1 && n < 2000);
    if (n >= 2000) chk("update pulse", 16'h0001, 16'h0000);
  endtask

  // the first interval after a change may be a transient, so the third is measured
  task automatic rate(input int e);
    repeat (3) wait_upd();
    chk("update interval", e[15:0], n[15:0]);
  endtask

  task automatic seq_sync(input logic [15:0] top);
    logic [15:0] d;
    logic        ok;
    for (int i = 0; i < 40; i++) begin
      wait_upd();
      h.rd(ADDR_SEQ, d, ok);
      if (d === top) break;
    end
  endtask

  task automatic seq_walk(input logic [15:0] top);
    for (logic [15:0] i = 16'h0001; i <= top; i++) begin
      wait_upd();
      rchk(ADDR_SEQ, (i == top) ? top : top - i);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #(TICK * 50 * 2000);
    chk("watchdog", 16'h0000, 16'h0001);
    results();
  end

  initial begin
    void'($urandom(61));
    va = 16'($urandom_range(16'h3fff));
    vb = va;
    smp_valid = 1'b1;
    gpio4_dir = 1'b1;
    gpio4_level = 1'($urandom);
    mag_in = {$urandom, $urandom};
    repeat (6) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    rchk(ADDR_SMPL_LO, SMPL_RST);
    rchk(ADDR_AVG_LO, AVG_RST);
    rchk(7'h7e, 16'h0000);
    for (int i = 0; i < 11; i++) begin
      h.send(1'b1, tbl[i][30:24], tbl[i][23:16]);
      rchk(tbl[i][30:24] & ADDR_WORD_MSK, tbl[i][15:0]);
    end
    $display("test registers done");
    chk("line out", {15'h0, gpio4_level}, {15'h0, line_out});
    chk("line enable", 16'h0001, {15'h0, line_oe});
    rate(TICK);
    seq_sync(16'h0010);
    rchk(ADDR_DIAG, 16'h0080);
    rchk(ADDR_DIAG, 16'h0080);
    rchk(ADDR_MAG, mag_in[0]);
    rchk(ADDR_DIAG, 16'h0000);
    seq_walk(16'h0010);
    rchk(ADDR_DIAG, 16'h0080);
    $display("test full rate done");
    vb = 16'($urandom_range(16'h3fff));
    // two-tap stages over alternating words settle on their mean, as does the decimator
    h.send(1'b1, ADDR_AVG_LO, 8'h01);
    h.send(1'b1, ADDR_SMPL_HI, 8'h01);
    rate(2 * TICK);
    repeat (2) wait_upd();
    rchk(ADDR_INERT, exp_avg(va, vb));
    rchk(ADDR_INERT + 7'h0a, exp_avg(va, vb));
    vb = va;
    h.send(1'b1, ADDR_SMPL_HI, 8'h02);
    rate(4 * TICK);
    rchk(ADDR_TEMP, va);
    rchk(ADDR_INERT, va);
    seq_sync(exp_span(2));
    rchk(ADDR_MAG + 7'h02, mag_in[1]);
    seq_walk(exp_span(2));
    rchk(ADDR_DIAG, 16'h0080);
    // above four the counter parks at 1 and every output update is a magnetic one
    h.send(1'b1, ADDR_SMPL_HI, 8'h05);
    seq_sync(16'h0001);
    rchk(ADDR_MAG + 7'h04, mag_in[2]);
    wait_upd();
    rchk(ADDR_DIAG, 16'h0080);
    rchk(ADDR_SEQ, 16'h0001);
    $display("test decimation done");
    h.send(1'b1, ADDR_SMPL_HI, 8'h00);
    h.send(1'b1, ADDR_SMPL_LO, 8'h00);
    repeat (3) @(posedge sys_clk);
    #1;
    chk("line enable", 16'h0000, {15'h0, line_oe});
    gpio4_dir = 1'b0;
    ext_on = 1'b1;
    rate(30);
    seq_sync(16'h0010);
    seq_walk(16'h0010);
    ext_on = 1'b0;
    h.send(1'b1, ADDR_SMPL_LO, 8'h01);
    rate(TICK);
    $display("test external clock done");
    results();
  end
endmodule
